/* smcu_pkg.sv */
// Constants for the stack math command unit
package smcu_pkg;
	// Wishbone register offsets (byte addresses)
	localparam logic [3:0] ADR_CMD    = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_DATA32 = 4'h8;
	localparam logic [3:0] ADR_DATA16 = 4'hC;
	// Command byte layout
	localparam int CMD_SR_BIT = 7;
	// Seven-bit operation codes
	localparam logic [6:0] OP_NOP      = 7'h00;
	localparam logic [6:0] OP_SIN      = 7'h02;
	localparam logic [6:0] OP_LOG      = 7'h08;
	localparam logic [6:0] OP_LN       = 7'h09;
	localparam logic [6:0] OP_PWR      = 7'h0B;
	localparam logic [6:0] OP_DUP32ALT = 7'h17;
	localparam logic [6:0] OP_POP32ALT = 7'h18;
	localparam logic [6:0] OP_PUSHPI   = 7'h1A;
	localparam logic [6:0] OP_DUP32    = 7'h37;
	localparam logic [6:0] OP_POP32    = 7'h38;
	localparam logic [6:0] OP_ADD16    = 7'h6C;
	localparam logic [6:0] OP_DIV16    = 7'h6F;
	localparam logic [6:0] OP_DUP16    = 7'h77;
	localparam logic [6:0] OP_POP16    = 7'h78;
	// Status byte fields
	localparam int ST_BUSY  = 7;
	localparam int ST_SIGN  = 6;
	localparam int ST_ZERO  = 5;
	localparam int ST_EF_LO = 1;
	localparam int ST_CARRY = 0;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// Error field codes
	localparam logic [3:0] EF_NONE  = 4'h0;
	localparam logic [3:0] EF_OVF   = 4'h1;
	localparam logic [3:0] EF_UNF   = 4'h2;
	localparam logic [3:0] EF_NEG   = 4'h4;
	localparam logic [3:0] EF_DIV0  = 4'h8;
	localparam logic [3:0] EF_RANGE = 4'hC;
	// Single-precision pi
	localparam logic [31:0] PI_FLOAT = 32'h40490FDB;
	// Exponent below which sine takes the short path
	localparam logic [7:0] SIN_SMALL_EXP = 8'h73;
	// Execution times in clock cycles, plus counter width and stack depth in halfwords
	localparam int CNT_W     = 14;
	localparam int NOP_CYC   = 4;
	localparam int POP32_CYC = 12;
	localparam int POP16_CYC = 10;
	localparam int DUP32_CYC = 20;
	localparam int DUP16_CYC = 16;
	localparam int PI_CYC    = 16;
	localparam int ADD_CYC   = 16;
	localparam int NEG_CYC   = 20;
	localparam int SIN_CYC   = 3796;
	localparam int SINS_CYC  = 30;
	localparam int UNK_CYC   = 4;
	localparam int STACK_HW  = 8;
endpackage : smcu_pkg

/* smcu_unit.sv */
// Stack math command unit with Wishbone register access
//
// Summary of operation
// RL1 - Log10 replaces 32-bit top, keeps next, clears rest; 4474 to 7132 cycles.
// RL2 - Log10 of negative operand sets error 0100 and finishes in 20 cycles.
// RL3 - Natural log replaces 32-bit top, keeps next only; 4298 to 6956 cycles.
// RL4 - Natural log of negative operand sets error 0100, short 20-cycle path.
// RL5 - No-op keeps the stack, takes 4 cycles, sets or clears service request.
// RL6 - No-op clears the whole status byte.
// RL7 - Both 32-bit pop codes rotate stack up, old top to bottom, 12 cycles.
// RL8 - 16-bit pop rotates the halfword stack up, old top to bottom, 10 cycles.
// RL9 - Both 32-bit duplicate codes push down copying top, drop bottom, 20 cycles.
// RL10 - 16-bit duplicate pushes down copying top, drops bottom, 16 cycles.
// RL11 - Push pi moves stack down, loads pi on top, loses bottom, 16 cycles.
// RL12 - Power raises next to top, result on top, keeps third; 8290 to 12032.
// RL13 - Power with negative base sets error 0100.
// RL14 - Power is exp of top times ln next; range error and over/underflow reported.
// RL15 - 16-bit add: sum on top, carry and overflow recorded, 16 to 18 cycles.
// RL16 - 16-bit divide: quotient on top; zero divisor returns dividend, error 1000.
// RL17 - Sine replaces top, keeps next; 3796 to 4808 cycles, 30 when tiny.
// RL18 - Host sets the top command bit to request service on completion.
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
module smcu_unit
	import smcu_pkg::*;
#(
	parameter int LOG_CYC = 4474,
	parameter int LN_CYC  = 4298,
	parameter int PWR_CYC = 8290,
	parameter int DIV_CYC = 84
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	// Float function engine
	output logic             fnStart,
	output logic      [6:0]  fnOp,
	output logic      [31:0] fnArgA,
	output logic      [31:0] fnArgB,
	input  wire logic [31:0] fnResult,
	input  wire logic        fnRangeErr,
	input  wire logic        fnOvf,
	input  wire logic        fnUnf,
	// Completion
	output logic             serviceReq,
	output logic             cmdDone
);
	// Parameter sanity
	if (LOG_CYC <= NEG_CYC || LN_CYC <= NEG_CYC || PWR_CYC < 1 || DIV_CYC < 1 ||
	    LOG_CYC >= 2**CNT_W || LN_CYC >= 2**CNT_W || PWR_CYC >= 2**CNT_W || DIV_CYC >= 2**CNT_W) begin : g_chk
		$error("smcu_unit: cycle parameter out of range");
	end

	logic              ackQ;
	logic [31:0]       rdatQ;
	logic              busyQ;
	logic [CNT_W-1:0]  cntQ;
	logic [CNT_W-1:0]  durD;
	logic [7:0]        cmdQ;
	logic [6:0]        opQ;
	logic              negQ;
	logic              srvQ;
	logic              fnStartQ;
	logic [6:0]        fnOpQ;
	logic [31:0]       fnArgAQ;
	logic [31:0]       fnArgBQ;
	logic [7:0]        statQ;
	logic [15:0]       stkQ [STACK_HW];
	logic [15:0]       nx [STACK_HW];
	logic [3:0]        efD;
	logic              carD;
	logic              signD;
	logic              zeroD;
	logic              busReq;
	logic              wrEn;
	logic              cmdAccept;
	logic              done;
	logic [6:0]        newOp;
	logic [15:0]       top16;
	logic [15:0]       next16;
	logic [31:0]       top32;
	logic [31:0]       next32;
	logic [16:0]       sum17;
	logic [15:0]       sum16;
	logic [15:0]       quot16;
	logic [15:0]       divSafe;

	// Operand views
	assign top16  = stkQ[0];
	assign next16 = stkQ[1];
	assign top32  = {stkQ[1], stkQ[0]};
	assign next32 = {stkQ[3], stkQ[2]};
	assign sum17  = {1'b0, top16} + {1'b0, next16};
	assign sum16  = sum17[15:0];
	// Divisor forced nonzero so the divider never sees zero
	assign divSafe = (top16 == 16'h0000) ? 16'h0001 : top16;
	assign quot16  = 16'($signed(next16) / $signed(divSafe));

	// Bus strobes; a write takes effect on the acknowledged edge
	assign busReq    = wb_cyc_i && wb_stb_i;
	assign wrEn      = busReq && wb_we_i && ackQ;
	assign newOp     = wb_dat_i[6:0];
	assign cmdAccept = wrEn && wb_adr_i == ADR_CMD && wb_sel_i[0] && !busyQ;
	assign done      = busyQ && cntQ == '0;

	assign wb_ack_o   = ackQ;
	assign wb_dat_o   = rdatQ;
	assign fnStart    = fnStartQ;
	assign fnOp       = fnOpQ;
	assign fnArgA     = fnArgAQ;
	assign fnArgB     = fnArgBQ;
	assign serviceReq = srvQ;
	assign cmdDone    = done;

	// Single-wait acknowledge, dropped the cycle after it was given
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ackQ  <= 1'b0;
			rdatQ <= 32'h00000000;
		end else begin
			ackQ <= busReq && !ackQ;
			if (busReq && !ackQ) begin
				unique case (wb_adr_i)
					ADR_CMD:    rdatQ <= {24'h000000, cmdQ};
					ADR_STATUS: rdatQ <= {24'h000000, busyQ, statQ[ST_BUSY-1:0]};
					ADR_DATA32: rdatQ <= top32;
					ADR_DATA16: rdatQ <= {16'h0000, top16};
					default:    rdatQ <= 32'h00000000; // Unmapped reads zero
				endcase
			end
		end
	end

	// Execution time picked from the command and its operands
	always_comb begin
		unique case (newOp)
			OP_NOP:                durD = CNT_W'(NOP_CYC - 1); // RL5
			OP_POP32, OP_POP32ALT: durD = CNT_W'(POP32_CYC - 1); // RL7
			OP_POP16:              durD = CNT_W'(POP16_CYC - 1); // RL8
			OP_DUP32, OP_DUP32ALT: durD = CNT_W'(DUP32_CYC - 1); // RL9
			OP_DUP16:              durD = CNT_W'(DUP16_CYC - 1); // RL10
			OP_PUSHPI:             durD = CNT_W'(PI_CYC - 1); // RL11
			OP_PWR:                durD = CNT_W'(PWR_CYC - 1); // RL12
			OP_ADD16:              durD = CNT_W'(ADD_CYC - 1); // RL15
			OP_DIV16:              durD = CNT_W'(DIV_CYC - 1);
			OP_LOG:                durD = top32[31] ? CNT_W'(NEG_CYC - 1) : CNT_W'(LOG_CYC - 1); // RL1 RL2
			OP_LN:                 durD = top32[31] ? CNT_W'(NEG_CYC - 1) : CNT_W'(LN_CYC - 1); // RL3 RL4
			OP_SIN:                durD = (top32[30:23] < SIN_SMALL_EXP) ? CNT_W'(SINS_CYC - 1)
			                                                           : CNT_W'(SIN_CYC - 1); // RL17
			default:               durD = CNT_W'(UNK_CYC - 1);
		endcase
	end

	// Command sequencer; writes while busy are dropped
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busyQ <= 1'b0;
			cntQ  <= '0;
			cmdQ  <= 8'h00;
			opQ   <= OP_NOP;
			negQ  <= 1'b0;
		end else if (cmdAccept) begin
			busyQ <= 1'b1;
			cntQ  <= durD;
			cmdQ  <= wb_dat_i[7:0];
			opQ   <= newOp;
			// Power checks the base, the others the top
			negQ  <= (newOp == OP_PWR) ? next32[31] : top32[31]; // RL13
		end else if (done) begin
			busyQ <= 1'b0;
		end else if (busyQ) begin
			cntQ <= cntQ - CNT_W'(1);
		end
	end

	// Service request follows the top command bit at completion
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			srvQ <= 1'b0;
		end else if (cmdAccept) begin
			srvQ <= 1'b0;
		end else if (done) begin
			srvQ <= cmdQ[CMD_SR_BIT]; // RL18 RL5
		end
	end

	// Float engine request, launched one cycle after acceptance
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fnStartQ <= 1'b0;
			fnOpQ    <= OP_NOP;
			fnArgAQ  <= 32'h00000000;
			fnArgBQ  <= 32'h00000000;
		end else begin
			fnStartQ <= cmdAccept && (newOp == OP_LOG || newOp == OP_LN || newOp == OP_SIN || newOp == OP_PWR);
			if (cmdAccept) begin
				fnOpQ   <= newOp;
				fnArgAQ <= top32;
				fnArgBQ <= next32; // RL14
			end
		end
	end

	// Stack effect and status of the finishing command
	always_comb begin
		for (int i = 0; i < STACK_HW; i++) nx[i] = stkQ[i];
		efD  = EF_NONE;
		carD = 1'b0;
		unique case (opQ)
			OP_LOG, OP_LN, OP_SIN: begin
				if (negQ && opQ != OP_SIN) begin
					efD = EF_NEG; // RL2 RL4
				end else begin
					{nx[1], nx[0]} = fnResult; // RL1 RL3 RL17
					for (int i = 4; i < STACK_HW; i++) begin
						nx[i] = 16'h0000;
					end
				end
			end
			OP_PWR: begin
				{nx[1], nx[0]} = fnResult; // RL12
				nx[2] = stkQ[4];
				nx[3] = stkQ[5];
				for (int i = 4; i < STACK_HW; i++) nx[i] = 16'h0000;
				if (negQ) begin
					efD = EF_NEG; // RL13
				end else if (fnRangeErr) begin
					efD = EF_RANGE; // RL14
				end else if (fnOvf) begin
					efD = EF_OVF; // RL14
				end else if (fnUnf) begin
					efD = EF_UNF; // RL14
				end
			end
			OP_POP32, OP_POP32ALT: begin
				for (int i = 0; i < STACK_HW - 2; i++) nx[i] = stkQ[i+2]; // RL7
				nx[STACK_HW-2] = stkQ[0];
				nx[STACK_HW-1] = stkQ[1];
			end
			OP_POP16: begin
				for (int i = 0; i < STACK_HW - 1; i++) nx[i] = stkQ[i+1]; // RL8
				nx[STACK_HW-1] = stkQ[0];
			end
			OP_DUP32, OP_DUP32ALT, OP_PUSHPI: begin
				for (int i = 2; i < STACK_HW; i++) nx[i] = stkQ[i-2]; // RL9
				if (opQ == OP_PUSHPI) begin
					{nx[1], nx[0]} = PI_FLOAT; // RL11
				end
			end
			OP_DUP16: begin
				for (int i = 1; i < STACK_HW; i++) nx[i] = stkQ[i-1]; // RL10
			end
			OP_ADD16, OP_DIV16: begin
				for (int i = 1; i < STACK_HW - 1; i++) nx[i] = stkQ[i+1];
				if (opQ == OP_ADD16) begin
					// Addend A goes to the bottom, B is consumed
					nx[0] = sum16; // RL15
					nx[STACK_HW-1] = stkQ[0];
					carD = sum17[16];
					if (top16[15] == next16[15] && sum16[15] != top16[15]) begin
						efD = EF_OVF; // RL15
					end
				end else begin
					nx[STACK_HW-1] = 16'h0000;
					if (top16 == 16'h0000) begin
						nx[0] = next16; // RL16
						efD = EF_DIV0; // RL16
					end else begin
						nx[0] = quot16; // RL16
						if (top16 == 16'hFFFF && next16 == 16'h8000) begin
							efD = EF_OVF;
						end
					end
				end
			end
			default: begin
			end
		endcase
		// Sign and zero track the width the command works in
		if (opQ == OP_POP16 || opQ == OP_DUP16 || opQ == OP_ADD16 || opQ == OP_DIV16) begin
			signD = nx[0][15];
			zeroD = nx[0] == 16'h0000;
		end else begin
			signD = nx[1][15];
			zeroD = {nx[1], nx[0]} == 32'h00000000;
		end
	end

	// Operand stack; host pushes only land while idle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < STACK_HW; i++) stkQ[i] <= 16'h0000;
		end else if (done) begin
			for (int i = 0; i < STACK_HW; i++) stkQ[i] <= nx[i];
		end else if (wrEn && !busyQ && wb_adr_i == ADR_DATA32 && wb_sel_i == 4'hF) begin
			for (int i = 2; i < STACK_HW; i++) stkQ[i] <= stkQ[i-2];
			stkQ[1] <= wb_dat_i[31:16];
			stkQ[0] <= wb_dat_i[15:0];
		end else if (wrEn && !busyQ && wb_adr_i == ADR_DATA16 && wb_sel_i[1:0] == 2'b11) begin
			for (int i = 1; i < STACK_HW; i++) stkQ[i] <= stkQ[i-1];
			stkQ[0] <= wb_dat_i[15:0];
		end
	end

	// Status byte, rewritten by every finished command
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			statQ <= STATUS_RST;
		end else if (done) begin
			if (opQ == OP_NOP) begin
				statQ <= STATUS_RST; // RL6
			end else begin
				statQ <= STATUS_RST;
				statQ[ST_SIGN] <= signD;
				statQ[ST_ZERO] <= zeroD;
				statQ[ST_EF_LO+3:ST_EF_LO] <= efD;
				statQ[ST_CARRY] <= carD;
			end
		end
	end

	a_nop_time: assert property (@(posedge core_clk) disable iff (!rst_b) // RL5
		cmdAccept && newOp == OP_NOP |-> !done [*4] ##1 done)
		else $error("no-op did not finish in 4 cycles");
	a_nop_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // RL6
		done && opQ == OP_NOP |=> statQ == 8'h00 && !busyQ)
		else $error("no-op left status bits set");
	a_pop32_time: assert property (@(posedge core_clk) disable iff (!rst_b) // RL7
		cmdAccept && (newOp == OP_POP32 || newOp == OP_POP32ALT) |-> ##12 done ##1 stkQ[6] == $past(stkQ[0], 13))
		else $error("32-bit pop wrong time or rotation");
	a_pop16_time: assert property (@(posedge core_clk) disable iff (!rst_b) // RL8
		cmdAccept && newOp == OP_POP16 |-> ##10 done)
		else $error("16-bit pop not 10 cycles");
	a_dup32_copy: assert property (@(posedge core_clk) disable iff (!rst_b) // RL9
		cmdAccept && (newOp == OP_DUP32 || newOp == OP_DUP32ALT) |-> ##20 done ##1 (top32 == next32))
		else $error("32-bit duplicate wrong");
	a_dup16_time: assert property (@(posedge core_clk) disable iff (!rst_b) // RL10
		cmdAccept && newOp == OP_DUP16 |-> ##16 done ##1 top16 == next16)
		else $error("16-bit duplicate wrong");
	a_pi_load: assert property (@(posedge core_clk) disable iff (!rst_b) // RL11
		cmdAccept && newOp == OP_PUSHPI |-> ##16 done ##1 top32 == PI_FLOAT)
		else $error("pi not on top after 16 cycles");
	a_log_neg: assert property (@(posedge core_clk) disable iff (!rst_b) // RL2
		cmdAccept && newOp == OP_LOG && top32[31] |-> ##20 done ##1 statQ[4:1] == 4'h4)
		else $error("negative log not flagged in 20 cycles");
	a_add_sum: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
		done && opQ == OP_ADD16 |=> top16 == 16'($past(top16) + $past(next16)) &&
		statQ[0] == (17'($past(top16)) + 17'($past(next16)) > 17'h0FFFF))
		else $error("16-bit add sum or carry wrong");
	a_div_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // RL16
		done && opQ == OP_DIV16 && top16 == 16'h0000 |=> top16 == $past(next16) && statQ[4:1] == 4'h8)
		else $error("divide by zero handling wrong");
endmodule : smcu_unit

/* smcu_fn_model.sv */
// Behavioural float function engine facing the command unit
`timescale 1ns/1ns
module smcu_fn_model
	import smcu_pkg::*;
(
	// Clock and job request
	input  wire logic        core_clk,
	input  wire logic        fnStart,
	input  wire logic [6:0]  fnOp,
	input  wire logic [31:0] fnArgA,
	input  wire logic [31:0] fnArgB,
	// Fault choice from the bench
	input  wire logic [2:0]  flagSel,
	// Answer
	output logic      [31:0] fnResult,
	output logic             fnRangeErr,
	output logic             fnOvf,
	output logic             fnUnf
);
	// Fixed mix of the arguments, so the bench can predict it without real maths
	always_ff @(posedge core_clk) begin
		if (fnStart) begin
			fnResult <= fnArgA ^ {fnArgB[15:0], fnArgB[31:16]} ^ {25'h0, fnOp};
			{fnRangeErr, fnOvf, fnUnf} <= flagSel;
		end
	end
endmodule : smcu_fn_model

/* test_stack_math_command_unit.sv */
// Self-checking bench for the stack math command unit
`timescale 1ns/1ns
module test_stack_math_command_unit
	import smcu_pkg::*;
	;
	// Short float times keep the run brief
	localparam int LOGC = 40;
	localparam int LNC  = 40;
	localparam int PWRC = 40;
	localparam int DIVC = 20;
	logic              core_clk = 1'b0;
	logic              rst_b    = 1'b0;
	logic              wb_cyc_i = 1'b0;
	logic              wb_stb_i = 1'b0;
	logic              wb_we_i  = 1'b0;
	logic       [3:0]  wb_adr_i = 4'h0;
	logic       [3:0]  wb_sel_i = 4'h0;
	logic       [31:0] wb_dat_i = 32'h0;
	logic       [2:0]  flagSel  = 3'h0;
	logic       [31:0] rdat;
	wire logic         wb_ack_o, fnStart, fnRangeErr, fnOvf, fnUnf, serviceReq, cmdDone;
	wire logic  [31:0] wb_dat_o, fnArgA, fnArgB, fnResult;
	wire logic  [6:0]  fnOp;
	logic       [15:0] h [8];
	int                n_fail   = 0;
	int                compares = 0;
	int                seed     = 32'h049b;

	smcu_unit #(.LOG_CYC(LOGC), .LN_CYC(LNC), .PWR_CYC(PWRC), .DIV_CYC(DIVC)) smcu_unit_i (.core_clk, .rst_b,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .fnStart, .fnOp,
		.fnArgA, .fnArgB, .fnResult, .fnRangeErr, .fnOvf, .fnUnf, .serviceReq, .cmdDone);
	smcu_fn_model smcu_fn_model_i (.core_clk, .fnStart, .fnOp, .fnArgA, .fnArgB, .flagSel, .fnResult,
		.fnRangeErr, .fnOvf, .fnUnf);

	// Clock, 4 ns period
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : checkVal

	task automatic checkCyc(input int got, input int exp);
		checkVal(got, exp);
	endtask : checkCyc

	// Classic single cycle; one idle cycle follows every transfer
	task automatic wbXfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk);
	endtask : wbXfer

	task automatic push32(input logic [31:0] v);
		wbXfer(1'b1, ADR_DATA32, 4'hF, v);
		for (int k = 7; k > 1; k--) h[k] = h[k - 2];
		{h[1], h[0]} = v;
	endtask : push32

	task automatic push16(input logic [15:0] v);
		wbXfer(1'b1, ADR_DATA16, 4'h3, {16'h0, v});
		for (int k = 7; k > 0; k--) h[k] = h[k - 1];
		h[0] = v;
	endtask : push16

	// Predict one command on the model stack, run it and compare
	task automatic doCmd(input logic [7:0] cmd);
		logic [15:0] o [8];
		logic [3:0]  ef;
		logic [1:0]  sz;
		logic        cy;
		logic        w16;
		int          n;
		int          k;
		o = h;
		ef = EF_NONE;
		cy = 1'b0;
		w16 = 1'b0;
		n = UNK_CYC;
		case (cmd[6:0])
			OP_NOP: n = NOP_CYC;
			OP_POP32, OP_POP32ALT: begin
				n = POP32_CYC;
				for (k = 0; k < 8; k++) h[k] = o[(k + 2) % 8];
			end
			OP_POP16: begin
				n = POP16_CYC;
				w16 = 1'b1;
				for (k = 0; k < 8; k++) h[k] = o[(k + 1) % 8];
			end
			OP_DUP32, OP_DUP32ALT, OP_PUSHPI: begin
				n = (cmd[6:0] == OP_PUSHPI) ? PI_CYC : DUP32_CYC;
				for (k = 2; k < 8; k++) h[k] = o[k - 2];
				if (cmd[6:0] == OP_PUSHPI) {h[1], h[0]} = PI_FLOAT;
			end
			OP_DUP16: begin
				n = DUP16_CYC;
				w16 = 1'b1;
				for (k = 1; k < 8; k++) h[k] = o[k - 1];
			end
			OP_ADD16, OP_DIV16: begin
				w16 = 1'b1;
				for (k = 1; k < 7; k++) h[k] = o[k + 1];
				h[7] = (cmd[6:0] == OP_ADD16) ? o[0] : 16'h0;
				if (cmd[6:0] == OP_ADD16) begin
					n = ADD_CYC;
					{cy, h[0]} = {1'b0, o[0]} + {1'b0, o[1]};
					if (o[0][15] == o[1][15] && h[0][15] != o[0][15]) ef = EF_OVF;
				end else begin
					n = DIVC;
					h[0] = (o[0] == 16'h0) ? o[1] : 16'($signed(o[1]) / $signed(o[0]));
					if (o[0] == 16'h0) ef = EF_DIV0;
					else if (o[0] == 16'hFFFF && o[1] == 16'h8000) ef = EF_OVF;
				end
			end
			OP_LOG, OP_LN, OP_SIN, OP_PWR: begin
				n = (cmd[6:0] == OP_LOG) ? LOGC : (cmd[6:0] == OP_LN) ? LNC : PWRC;
				if (cmd[6:0] == OP_SIN) n = (o[1][14:7] < SIN_SMALL_EXP) ? SINS_CYC : SIN_CYC;
				{h[1], h[0]} = {o[1], o[0]} ^ {o[2], o[3]} ^ {25'h0, cmd[6:0]};
				for (k = 2; k < 8; k++) h[k] = 16'h0;
				if (cmd[6:0] == OP_PWR) begin
					{h[3], h[2]} = {o[5], o[4]};
					ef = o[3][15] ? EF_NEG : flagSel[2] ? EF_RANGE : flagSel[1] ? EF_OVF : flagSel[0] ? EF_UNF : EF_NONE;
				end else if (cmd[6:0] != OP_SIN && o[1][15]) begin
					n = NEG_CYC;
					ef = EF_NEG;
					h = o;
				end else begin
					{h[3], h[2]} = {o[3], o[2]};
				end
			end
			default: n = UNK_CYC;
		endcase
		sz = w16 ? {h[0][15], h[0] == 16'h0} : {h[1][15], {h[1], h[0]} == 32'h0};
		wbXfer(1'b1, ADR_CMD, 4'h1, {24'h0, cmd});
		k = 1;
		while (cmdDone !== 1'b1 && k < 5000) begin
			@(posedge core_clk);
			k++;
		end
		checkCyc(k, n);
		wbXfer(1'b0, ADR_STATUS, 4'hF, 32'h0);
		checkVal(rdat, (cmd[6:0] == OP_NOP) ? 32'h0 : {24'h0, 1'b0, sz, ef, cy});
		wbXfer(1'b0, ADR_DATA32, 4'hF, 32'h0);
		checkVal(rdat, {h[1], h[0]});
		checkVal({31'h0, serviceReq}, {31'h0, cmd[7]});
	endtask : doCmd

	// Hang guard, well above the expected run
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		logic [6:0] ops [7];
		ops = '{OP_POP32, OP_POP32ALT, OP_POP16, OP_DUP32, OP_DUP32ALT, OP_DUP16, OP_PUSHPI};
		for (int i = 0; i < 8; i++) h[i] = 16'h0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		wbXfer(1'b0, ADR_STATUS, 4'hF, 32'h0);
		checkVal(rdat, {24'h0, STATUS_RST});
		for (int i = 0; i < 4; i++) push32($random(seed));
		push16(16'h8000);
		push16(16'h8001);
		doCmd({1'b1, OP_ADD16});
		push16(16'($random(seed)));
		push16(16'h0);
		doCmd({1'b0, OP_DIV16});
		push16(16'($random(seed)));
		push16(16'($random(seed)) | 16'h0001);
		doCmd({1'b1, OP_DIV16});
		push16(16'h8000);
		push16(16'hFFFF);
		doCmd({1'b0, OP_DIV16});
		doCmd({1'b1, 7'h7F});
		doCmd({1'b1, OP_NOP});
		doCmd({1'b0, OP_NOP});
		for (int i = 0; i < 7; i++) doCmd({i[0], ops[i]});
		for (int i = 0; i < 4; i++) doCmd({1'b0, OP_POP32});
		for (int i = 0; i < 4; i++) begin
			push32({i[0], 31'($random(seed))});
			doCmd({1'b0, i < 2 ? OP_LOG : OP_LN});
		end
		push32({1'b0, 8'h10, 23'($random(seed))});
		doCmd({1'b1, OP_SIN});
		push32({1'b0, 8'h80, 23'($random(seed))});
		doCmd({1'b0, OP_SIN});
		for (int i = 0; i < 5; i++) begin
			flagSel <= (i < 4) ? 3'(4 >> (3 - i)) : 3'h7;
			push32({i == 4, 31'($random(seed))});
			push32($random(seed));
			doCmd({1'b0, OP_PWR});
		end
		for (int i = 0; i < 4; i++) doCmd({1'b0, OP_POP32});
		tally_and_finish();
	end
endmodule : test_stack_math_command_unit
